// >>> usc_regs.vh
// Register offsets, field positions and reset values of the serial core.
`ifndef USC_REGS_VH
`define USC_REGS_VH
// ==========================================================================
// Register byte addresses (one aligned 32-bit word each).
`define USC_ADDR_DATA      4'h0
`define USC_ADDR_STAT_A    4'h4
`define USC_ADDR_STAT_B    4'h8
`define USC_ADDR_STAT_C    4'hC
// ==========================================================================
// Divisor registers sit above the control words.
`define USC_ADDR_DIV_LOW   5'h10
`define USC_ADDR_DIV_HIGH  5'h14
// ==========================================================================
// Field positions in ctrl_stat_a.
`define USC_A_DOUBLE_SPEED 1
`define USC_A_PARITY_ERR   2
`define USC_A_OVERRUN      3
`define USC_A_FRAMING_ERR  4
`define USC_A_TX_EMPTY     5
`define USC_A_TX_DONE      6
`define USC_A_RX_READY     7
// Field positions in ctrl_stat_b.
`define USC_B_TX_NINTH     0
`define USC_B_RX_NINTH     1
`define USC_B_CHAR_SIZE2   2
`define USC_B_TX_ENABLE    3
`define USC_B_RX_ENABLE    4
// Field positions in ctrl_stat_c.
`define USC_C_CLOCK_POL    0
`define USC_C_CHAR_SIZE0   1
`define USC_C_STOP_SELECT  3
`define USC_C_PARITY_MODE  4
`define USC_C_SYNC_SELECT  6
`define USC_C_XCK_DIR      7
// ==========================================================================
// Reset values.
`define USC_RST_STAT_B     8'h00
`define USC_RST_STAT_C     8'h06
`define USC_RST_DIV        12'h000
// Character size code that selects nine data bits.
`define USC_SIZE_NINE      3'h7
`endif

// >>> usc_core.v
// Serial transceiver core with baud generator, clock modes and a Wishbone slave.
`default_nettype none
`include "usc_regs.vh"

// Behaviour
// [R01] Baud down-counter reloads at zero or low write
// [R02] Transmit bit clock is tick/16, /8, /2
// [R03] Receiver sequencer runs on raw tick
// [R04] Bit rate follows divisor and mode
// [R05] Divisor is twelve bits in two bytes
// [R06] Sync select and clock direction pick mode
// [R07] Transfer clock pin used only in sync
// [R08] Double speed only affects async operation
// [R09] Double speed receiver uses eight samples
// [R10] External clock synchronised then edge detected
// [R11] External clock below quarter system clock
// [R12] Sync sampling edge opposite to change edge
// [R13] Clock polarity selects change and sample edges
// [R14] Frames of 5 to 9 bits, parity, stops
// [R15] Start, data LSB first, parity, stops
// [R16] Back-to-back frames or idle high line
// [R17] One frame format shared by both directions
// [R18] Only first stop bit checked for framing
// [R19] Parity is XOR of data, inverted odd
// [R20] One buffered character ahead of shifter
// [R21] Two-entry receive buffer behind shifter
// [R22] Framing, overrun and parity errors reported
// [R23] Size code seven gives nine-bit characters
// [R24] Async start validated at window centre
// [R25] Master clock output from divided transmit clock
module usc_core (
  input  wire        clk_i,        // System clock.
  input  wire        rst_i,        // Synchronous reset, active high.
  input  wire        wb_cyc_i,     // Wishbone cycle.
  input  wire        wb_stb_i,     // Wishbone strobe.
  input  wire        wb_we_i,      // Wishbone write enable.
  input  wire [4:0]  wb_adr_i,     // Wishbone byte address.
  input  wire [3:0]  wb_sel_i,     // Wishbone byte selects.
  input  wire [31:0] wb_dat_i,     // Wishbone write data.
  output reg  [31:0] wb_dat_o,     // Wishbone read data.
  output reg         wb_ack_o,     // Wishbone acknowledge.
  input  wire        serial_in_i,  // Receive data line.
  output reg         serial_out_o, // Transmit data line.
  input  wire        xck_i,        // Transfer clock pin level in.
  output reg         xck_o,        // Transfer clock pin level out.
  output wire        xck_oe_o      // Transfer clock pin drive enable.
);

  // ========================================================================
  // Control registers.
  reg [11:0] baud_divisor_ff;   // Twelve-bit divisor.
  reg        double_speed_ff;   // Double-speed asynchronous mode.
  reg [7:0]  ctrl_b_ff;         // Enables, size bit 2, transmit ninth bit.
  reg [7:0]  ctrl_c_ff;         // Mode, parity, stop, size, polarity.
  reg        pe_ff;             // Parity error of head entry.
  reg        ovr_ff;            // Overrun of head entry.
  reg        fe_ff;             // Framing error of head entry.

  wire [2:0] char_size     = {ctrl_b_ff[`USC_B_CHAR_SIZE2], ctrl_c_ff[2:1]};
  wire [1:0] parity_mode   = ctrl_c_ff[5:4];
  wire       stop_two      = ctrl_c_ff[`USC_C_STOP_SELECT];
  wire       sync_select   = ctrl_c_ff[`USC_C_SYNC_SELECT];
  wire       xck_dir       = ctrl_c_ff[`USC_C_XCK_DIR];
  wire       clock_pol     = ctrl_c_ff[`USC_C_CLOCK_POL];
  wire       tx_en         = ctrl_b_ff[`USC_B_TX_ENABLE];
  wire       rx_en         = ctrl_b_ff[`USC_B_RX_ENABLE];
  wire       sync_master   = sync_select & xck_dir;        // [R06]
  wire       sync_slave    = sync_select & ~xck_dir;       // [R06]
  wire       fast_async    = double_speed_ff & ~sync_select; // [R08]

  // Data bit count from the size code; codes 4..6 are treated as eight.
  function [3:0] bits_of;
    input [2:0] code;
    begin
      if (code == `USC_SIZE_NINE) begin
        bits_of = 4'h9;                                    // [R23]
      end else if (code < 3'h4) begin
        bits_of = {2'b00, code[1:0]} + 4'h5;               // [R14]
      end else begin
        bits_of = 4'h8;
      end
    end
  endfunction

  wire [3:0] nbits = bits_of(char_size);                   // [R17]

  // ========================================================================
  // Bus access decode.
  wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_req   = bus_req & wb_we_i & wb_sel_i[0];
  wire rd_req   = bus_req & ~wb_we_i;
  wire wr_data  = wr_req & (wb_adr_i == {1'b0, `USC_ADDR_DATA});
  wire wr_divlo = wr_req & (wb_adr_i == `USC_ADDR_DIV_LOW);
  wire rd_data  = rd_req & (wb_adr_i == {1'b0, `USC_ADDR_DATA});

  // ========================================================================
  // Baud generator: down-counter reloaded at zero or on a low-byte write.
  reg [11:0] baud_cnt_ff;
  wire       baud_tick = (baud_cnt_ff == 12'h000);          // [R01]

  always @(posedge clk_i) begin
    if (rst_i) begin
      baud_cnt_ff <= `USC_RST_DIV;
    end else if (baud_tick || wr_divlo) begin
      // The low write uses the new low byte straight from the bus.
      baud_cnt_ff <= wr_divlo ? {baud_divisor_ff[11:8], wb_dat_i[7:0]} : baud_divisor_ff; // [R01] [R05]
    end else begin
      baud_cnt_ff <= baud_cnt_ff - 12'h001;
    end
  end

  // ========================================================================
  // Transmit prescaler: ticks divided by 16, 8 or 2 into bit clocks.
  reg  [3:0] tx_pre_ff;
  wire [3:0] tx_pre_top = sync_master ? 4'h1 : (fast_async ? 4'h7 : 4'hF); // [R02] [R04]
  wire       tx_bit_int = baud_tick && (tx_pre_ff >= tx_pre_top);

  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_pre_ff <= 4'h0;
    end else if (baud_tick) begin
      tx_pre_ff <= tx_bit_int ? 4'h0 : tx_pre_ff + 4'h1;
    end
  end

  // Master clock out toggles at half periods so one period is one bit.
  always @(posedge clk_i) begin
    if (rst_i) begin
      xck_o <= 1'b0;
    end else if (!sync_master) begin
      xck_o <= clock_pol;                                  // Idle level.
    end else if (baud_tick) begin
      xck_o <= (tx_pre_ff == 4'h0) ? ~clock_pol : clock_pol; // [R25]
    end
  end

  assign xck_oe_o = sync_master;                           // [R07]

  // ========================================================================
  // Slave clock: two flops, then edge detect on the second (two-cycle delay).
  reg xck_s1_ff;
  reg xck_s2_ff;
  reg xck_s3_ff;

  always @(posedge clk_i) begin
    if (rst_i) begin
      xck_s1_ff <= 1'b0;
      xck_s2_ff <= 1'b0;
      xck_s3_ff <= 1'b0;
    end else begin
      xck_s1_ff <= xck_i & sync_slave;                     // [R07] [R10]
      xck_s2_ff <= xck_s1_ff;
      xck_s3_ff <= xck_s2_ff;
    end
  end

  // Relies on the external clock staying below a quarter of clk_i.
  wire ext_rise = xck_s2_ff & ~xck_s3_ff;                  // [R10] [R11]
  wire ext_fall = ~xck_s2_ff & xck_s3_ff;
  // Master edges are the toggles of xck_o seen next clock.
  wire m_rise   = sync_master & baud_tick & (tx_pre_ff == 4'h0);
  wire m_fall   = sync_master & baud_tick & (tx_pre_ff == 4'h1);
  wire pin_rise = sync_slave ? ext_rise : clock_pol ? m_fall : m_rise;
  wire pin_fall = sync_slave ? ext_fall : clock_pol ? m_rise : m_fall;
  // Change edge is rising when polarity is clear; sample on the other.
  wire chg_edge = clock_pol ? pin_fall : pin_rise;         // [R12] [R13]
  wire smp_edge = clock_pol ? pin_rise : pin_fall;         // [R12] [R13]
  wire tx_step  = sync_select ? chg_edge : tx_bit_int;

  // ========================================================================
  // Transmitter: one holding register ahead of the shift register.
  reg [8:0] tx_hold_ff;
  reg       tx_full_ff;
  reg [12:0] tx_shift_ff;                                  // Data, parity, stops.
  reg [3:0] tx_left_ff;
  reg       tx_busy_ff;
  reg       tx_done_ff;
  wire      tx_load = tx_full_ff && (!tx_busy_ff || (tx_step && tx_left_ff == 4'h0)); // [R20]

  // Parity over the active data bits only.
  wire [8:0] tx_mask = (9'h1FF >> (4'h9 - nbits));
  wire       tx_par  = ^(tx_hold_ff & tx_mask) ^ parity_mode[0]; // [R19]
  wire [3:0] tx_len  = nbits + {3'h0, parity_mode[1]} + {3'h0, stop_two} + 4'h1;

  // Frame word assembled LSB first: data, optional parity, then ones.
  reg [12:0] tx_frame;
  always @* begin
    tx_frame = {13{1'b1}};
    tx_frame[8:0] = tx_hold_ff | ~tx_mask;
    if (parity_mode[1]) begin
      tx_frame[nbits] = tx_par;                            // [R15]
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_hold_ff   <= 9'h000;
      tx_full_ff   <= 1'b0;
      tx_shift_ff  <= 13'h1FFF;
      tx_left_ff   <= 4'h0;
      tx_busy_ff   <= 1'b0;
      tx_done_ff   <= 1'b0;
      serial_out_o <= 1'b1;
    end else begin
      if (wr_data && !tx_full_ff) begin
        tx_hold_ff <= {ctrl_b_ff[`USC_B_TX_NINTH], wb_dat_i[7:0]}; // [R23]
        tx_full_ff <= 1'b1;
      end else if (tx_load) begin
        tx_full_ff <= 1'b0;
      end
      if (wr_req && wb_adr_i == {1'b0, `USC_ADDR_STAT_A} && wb_dat_i[`USC_A_TX_DONE]) begin
        tx_done_ff <= 1'b0;
      end
      if (tx_load && tx_en) begin
        tx_shift_ff <= tx_frame;
        tx_busy_ff  <= 1'b1;
        tx_left_ff  <= tx_len;
        tx_done_ff  <= 1'b0;
      end
      if (tx_busy_ff && tx_step) begin
        if (tx_left_ff == tx_len && serial_out_o) begin
          serial_out_o <= 1'b0;                            // Start bit. [R15]
        end else if (tx_left_ff != 4'h0) begin
          serial_out_o <= tx_shift_ff[0];                  // [R15]
          tx_shift_ff  <= {1'b1, tx_shift_ff[12:1]};
          tx_left_ff   <= tx_left_ff - 4'h1;
        end else if (tx_load && tx_en) begin
          serial_out_o <= 1'b0; // [R20]
        end else begin
          tx_busy_ff   <= 1'b0;                            // [R16]
          tx_done_ff   <= ~tx_full_ff;
        end
      end
    end
  end

  // ========================================================================
  // Receiver sequencer on the raw tick: 16 or 8 states per bit, async only; sync samples on pin edges.
  reg [3:0]  rx_ph_ff;
  reg [3:0]  rx_cnt_ff;
  reg        rx_busy_ff;
  reg [9:0]  rx_shift_ff;
  wire [3:0] rx_top = sync_master ? 4'h1 : (fast_async ? 4'h7 : 4'hF); // [R03] [R09]
  wire [3:0] rx_mid = fast_async ? 4'h3 : 4'h7;            // [R24]
  wire       rx_smp = sync_select ? smp_edge : (baud_tick && rx_ph_ff == rx_mid);
  wire [3:0] rx_len = nbits + {3'h0, parity_mode[1]} + 4'h1;
  wire       rx_done = rx_en && rx_busy_ff && rx_smp && rx_cnt_ff == rx_len; // [R18]
  reg        rx_hi_ff;
  reg        rx_in_ff;

  // Two-entry receive buffer: index 0 is the head.
  reg [8:0]  rxq_d  [0:1];
  reg [2:0]  rxq_e  [0:1];                                 // fe, ovr, pe.
  reg [1:0]  rxq_n_ff;

  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_in_ff <= 1'b1;
      rx_hi_ff <= 1'b1;
    end else begin
      rx_in_ff <= serial_in_i;
      rx_hi_ff <= baud_tick ? rx_in_ff : rx_hi_ff;
    end
  end

  // Received fields after the shift: data bits and parity.
  wire [8:0] rx_dat  = rx_shift_ff[8:0] >> (4'h9 - nbits) & tx_mask;
  wire       rx_pbit = rx_shift_ff[9];
  wire       rx_perr = parity_mode[1] & ((^rx_dat) ^ parity_mode[0] ^ rx_pbit); // [R19] [R22]

  always @(posedge clk_i) begin
    if (rst_i || !rx_en) begin
      rx_ph_ff    <= 4'h0;
      rx_cnt_ff   <= 4'h0;
      rx_busy_ff  <= 1'b0;
      rx_shift_ff <= 10'h000;
    end else if (!rx_busy_ff) begin
      // Async: wait for a high-to-low change between ticks, then verify at the window centre.
      if (sync_select ? (rx_smp && !rx_in_ff) : (baud_tick && !rx_in_ff && rx_hi_ff)) begin
        rx_busy_ff <= 1'b1;
        rx_ph_ff   <= 4'h1;
        rx_cnt_ff  <= sync_select ? 4'h1 : 4'h0;
      end
    end else begin
      if (baud_tick && !sync_select) begin
        rx_ph_ff <= (rx_ph_ff >= rx_top) ? 4'h0 : rx_ph_ff + 4'h1;
      end
      if (rx_smp) begin
        if (rx_cnt_ff == 4'h0 && rx_in_ff) begin
          rx_busy_ff <= 1'b0;                              // False start. [R24]
        end else if (rx_cnt_ff == rx_len) begin
          rx_busy_ff <= 1'b0;                              // First stop only. [R18]
        end else begin
          if (rx_cnt_ff != 4'h0) begin
            rx_shift_ff <= parity_mode[1] && rx_cnt_ff == rx_len - 4'h1 ?
                           {rx_in_ff, rx_shift_ff[8:0]} :
                           {1'b0, rx_in_ff, rx_shift_ff[8:1]}; // LSB first. [R15]
          end
          rx_cnt_ff <= rx_cnt_ff + 4'h1;
        end
      end
    end
  end

  // Queue maintenance; a full queue marks overrun on the tail entry and drops the new one.
  wire rx_pop  = rd_data && rxq_n_ff != 2'h0;
  wire rx_push = rx_done;
  wire [2:0] rx_err = {~rx_in_ff, 1'b0, rx_perr}; // [R18] [R22]

  always @(posedge clk_i) begin
    if (rst_i) begin
      rxq_n_ff <= 2'h0;
      rxq_d[0] <= 9'h000;
      rxq_d[1] <= 9'h000;
      rxq_e[0] <= 3'h0;
      rxq_e[1] <= 3'h0;
    end else begin
      if (rx_pop) begin
        rxq_d[0] <= rxq_d[1];
        rxq_e[0] <= rxq_e[1];
      end
      if (rx_push && rxq_n_ff == 2'h2 && !rx_pop) begin
        rxq_e[1][1] <= 1'b1;                               // Overrun. [R21] [R22]
      end else if (rx_push) begin
        if (rxq_n_ff - {1'b0, rx_pop} == 2'h0) begin
          rxq_d[0] <= rx_dat;
          rxq_e[0] <= rx_err;
        end else begin
          rxq_d[1] <= rx_dat;
          rxq_e[1] <= rx_err;
        end
        rxq_n_ff <= rxq_n_ff + 2'h1 - {1'b0, rx_pop};
      end else if (rx_pop) begin
        rxq_n_ff <= rxq_n_ff - 2'h1;
      end
    end
  end

  always @* begin
    fe_ff  = rxq_e[0][2];
    ovr_ff = rxq_e[0][1];
    pe_ff  = rxq_e[0][0];
  end

  // ========================================================================
  // Register writes and one-wait-state acknowledge.
  always @(posedge clk_i) begin
    if (rst_i) begin
      baud_divisor_ff <= `USC_RST_DIV;
      double_speed_ff <= 1'b0;
      ctrl_b_ff       <= `USC_RST_STAT_B;
      ctrl_c_ff       <= `USC_RST_STAT_C;
      wb_ack_o        <= 1'b0;
      wb_dat_o        <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (wr_req) begin
        if (wb_adr_i == {1'b0, `USC_ADDR_STAT_A}) begin
          double_speed_ff <= wb_dat_i[`USC_A_DOUBLE_SPEED];
        end else if (wb_adr_i == {1'b0, `USC_ADDR_STAT_B}) begin
          ctrl_b_ff <= wb_dat_i[7:0] & 8'h1D;              // Receive ninth bit is read-only.
        end else if (wb_adr_i == {1'b0, `USC_ADDR_STAT_C}) begin
          ctrl_c_ff <= wb_dat_i[7:0];
        end else if (wr_divlo) begin
          baud_divisor_ff[7:0] <= wb_dat_i[7:0];           // [R05]
        end else if (wb_adr_i == `USC_ADDR_DIV_HIGH) begin
          baud_divisor_ff[11:8] <= wb_dat_i[3:0];          // [R05]
        end
      end
      if (rd_req) begin
        if (wb_adr_i == {1'b0, `USC_ADDR_DATA}) begin
          wb_dat_o <= {24'h0, rxq_d[0][7:0]};
        end else if (wb_adr_i == {1'b0, `USC_ADDR_STAT_A}) begin
          wb_dat_o <= {24'h0, rxq_n_ff != 2'h0, tx_done_ff, ~tx_full_ff, fe_ff, ovr_ff, pe_ff,
                       double_speed_ff, 1'b0};
        end else if (wb_adr_i == {1'b0, `USC_ADDR_STAT_B}) begin
          wb_dat_o <= {24'h0, ctrl_b_ff[7:2], rxq_d[0][8], ctrl_b_ff[0]};
        end else if (wb_adr_i == {1'b0, `USC_ADDR_STAT_C}) begin
          wb_dat_o <= {24'h0, ctrl_c_ff};
        end else if (wb_adr_i == `USC_ADDR_DIV_LOW) begin
          wb_dat_o <= {24'h0, baud_divisor_ff[7:0]};
        end else if (wb_adr_i == `USC_ADDR_DIV_HIGH) begin
          wb_dat_o <= {28'h0, baud_divisor_ff[11:8]};
        end else begin
          wb_dat_o <= 32'h0000_0000;                       // Unmapped reads zero.
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> usc_props.sv
// Port-level assertions for the serial core.
`default_nettype none
`include "usc_regs.vh"
module usc_props (
  input wire logic        clk_i,        // System clock.
  input wire logic        rst_i,        // Synchronous reset, active high.
  input wire logic        wb_cyc_i,     // Bus cycle.
  input wire logic        wb_stb_i,     // Bus strobe.
  input wire logic        wb_we_i,      // Bus write enable.
  input wire logic [4:0]  wb_adr_i,     // Bus address.
  input wire logic [31:0] wb_dat_o,     // Bus read data.
  input wire logic        wb_ack_o,     // Bus acknowledge.
  input wire logic        serial_out_o, // Transmit line.
  input wire logic        xck_oe_o      // Transfer clock drive enable.
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Bus handshake.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // A request counts as taken only while no answer is pending.
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // The answer is a single pulse; a held strobe is answered again every second cycle.
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_bus_answer: assert property (s_req |=> s_ack)
    else $error("no single ack after a request");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack lasted more than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_unmapped_zero: assert property (
      (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i > `USC_ADDR_DIV_HIGH) |=> wb_dat_o == 32'h0)
    else $error("unmapped read returned data");
  a_dat_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved outside a read");
  // ==========================================================================
  // Line behaviour.
  a_reset_idle: assert property (
      $fell(rst_i) |-> serial_out_o && !xck_oe_o && !wb_ack_o)
    else $error("outputs not idle after reset");
  // The shortest bit in any mode lasts two system clocks.
  a_tx_hold: assert property (
      $changed(serial_out_o) |=> $stable(serial_out_o))
    else $error("transmit bit shorter than two clocks");
  // The pin direction only follows a register write.
  a_oe_cause: assert property (
      $changed(xck_oe_o) |-> (wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i))
    else $error("clock pin enable moved without a write");
endmodule
`default_nettype wire

// >>> usc_peer.sv
// Remote serial transceiver model on the core's data lines.
`default_nettype none
module usc_peer (
  input  wire logic clk_i,  // Time base, the system clock.
  input  wire logic line_i, // Line driven by the core.
  output var logic  line_o  // Line into the core.
);
  timeunit 1ns;
  timeprecision 1ns;
  // The line idles high, as a released line with pull-up would.
  initial line_o = 1'b1;
  // ==========================================================================
  // Send n bits, element zero first, each held bc clocks.
  task automatic send(input logic [11:0] bits, input int n, input int bc);
    int k;
    for (k = 0; k < n; k++) begin
      @(posedge clk_i) line_o <= bits[k];
      repeat (bc - 1) @(posedge clk_i);
    end
    @(posedge clk_i) line_o <= 1'b1;
  endtask
  // Wait for a start edge, then sample n bits at their centres.
  // It returns mid last bit, so a frame that follows at once is not missed.
  task automatic recv(input int n, input int bc, output logic [11:0] bits);
    int k;
    bits = 12'hFFF;
    k = 0;
    while (line_i !== 1'b0 && k < 4000) begin
      @(posedge clk_i);
      k++;
    end
    repeat (bc / 2) @(posedge clk_i);
    for (k = 0; k < n; k++) begin
      if (k > 0) repeat (bc) @(posedge clk_i);
      bits[k] = line_i;
    end
  endtask
endmodule
`default_nettype wire

// >>> usc_core_tb_top.sv
// Self-checking bench for the serial core.
`default_nettype none
`include "usc_regs.vh"
module usc_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i;   // System clock.
  logic        rst_i;   // Reset, active high.
  logic        wb_cyc;  // Bus cycle.
  logic        wb_stb;  // Bus strobe.
  logic        wb_we;   // Bus write enable.
  logic [4:0]  wb_adr;  // Bus address.
  logic [3:0]  wb_sel;  // Bus byte selects.
  logic [31:0] wb_wdat; // Bus write data.
  wire  [31:0] wb_rdat; // Bus read data.
  wire         wb_ack;  // Bus acknowledge.
  wire         tx_line; // Core to peer.
  wire         rx_line; // Peer to core.
  wire         xck_out; // Transfer clock from the core.
  wire         xck_oe;  // Transfer clock drive enable.
  wire         xck_pin; // Resolved pin level, pulled low when released.
  int          error_cnt; // Mismatches seen.
  int          checked;   // Comparisons made.
  int          cyc_cnt;   // Cycles since start.
  logic [31:0] rdat;      // Last value read.
  logic [11:0] got;       // Last frame seen on the line.
  localparam logic [2:0] sz_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7}; // Size codes.
  localparam logic [1:0] pm_tab [5] = '{2'h3, 2'h0, 2'h2, 2'h2, 2'h3}; // Parity modes.
  localparam logic [4:0] st_tab = 5'h0A; // Two stop bits where set.
  assign xck_pin = xck_oe ? xck_out : 1'b0;
  usc_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .serial_in_i(rx_line), .serial_out_o(tx_line), .xck_i(xck_pin), .xck_o(xck_out), .xck_oe_o(xck_oe));
  usc_peer u_peer (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line));
  // ==========================================================================
  // Clock, timeout and common tasks.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // A hang is cut short well beyond the run's length.
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One classic cycle; the request holds until ack is seen at an edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} <= {2'b11, w, a, 4'hF, 24'h0, d};
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rdat = wb_rdat;
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
  endtask
  // Expected frame: start, data low bit first, parity, stops left as ones.
  function automatic logic [11:0] frame(input logic [8:0] d, input int n, input int pm);
    logic [11:0] f;
    int k;
    f = 12'hFFE;
    for (k = 0; k < n; k++) f[k + 1] = d[k];
    if (pm >= 2) f[n + 1] = ^(d & ((9'h001 << n) - 9'h001)) ^ (pm == 3);
    return f;
  endfunction
  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    bus(1'b0, `USC_ADDR_STAT_C, 8'h00);
    chk("stat_c reset", rdat, {24'h0, `USC_RST_STAT_C});
    bus(1'b0, `USC_ADDR_STAT_B, 8'h00);
    chk("stat_b reset", rdat, {24'h0, `USC_RST_STAT_B});
    bus(1'b0, 5'h18, 8'h00);
    chk("unmapped read", rdat, 32'h0);
    bus(1'b1, `USC_ADDR_DIV_HIGH, 8'h00);
    bus(1'b1, `USC_ADDR_DIV_LOW, 8'h01);
  endtask
  task automatic tx_one(input logic [2:0] sz, input logic [1:0] pm, input logic st, input int bc);
    int n;
    n = (sz == 3'h7) ? 9 : 5 + sz;
    bus(1'b1, `USC_ADDR_STAT_C, {2'b00, pm, st, sz[1:0], 1'b0});
    bus(1'b1, `USC_ADDR_STAT_B, {3'b000, 2'b11, sz[2], 1'b0, 1'b1});
    fork
      u_peer.recv(n + 2 + (pm >= 2) + st, bc, got);
      bus(1'b1, `USC_ADDR_DATA, 8'hA5);
    join
    chk("tx frame", {20'h0, got}, {20'h0, frame(9'h1A5, n, pm)});
    // The format must not change while the last stop bit is still out.
    repeat (bc * 2) @(posedge clk_i);
  endtask
  task automatic t_tx();
    int k;
    for (k = 0; k < 5; k++) tx_one(sz_tab[k], pm_tab[k], st_tab[k], 32);
    bus(1'b1, `USC_ADDR_STAT_A, 8'h02);
    tx_one(3'h3, 2'h2, 1'b0, 16);
    bus(1'b1, `USC_ADDR_STAT_A, 8'h00);
  endtask
  task automatic t_back();
    logic [11:0] first;
    int c0;
    bus(1'b1, `USC_ADDR_STAT_C, 8'h06);
    fork
      begin
        u_peer.recv(10, 32, first);
        c0 = cyc_cnt;
        u_peer.recv(10, 32, got);
        chk("frame gap", cyc_cnt - c0, 320);
      end
      begin
        bus(1'b1, `USC_ADDR_DATA, 8'h5A);
        bus(1'b1, `USC_ADDR_DATA, 8'hC3);
      end
    join
    chk("first frame", {20'h0, first}, {20'h0, frame(9'h05A, 8, 0)});
    chk("second frame", {20'h0, got}, {20'h0, frame(9'h0C3, 8, 0)});
  endtask
  task automatic rx_one(input logic [7:0] c, input logic [11:0] flip, input int len, input logic [7:0] err);
    int k;
    bus(1'b1, `USC_ADDR_STAT_C, c);
    u_peer.send(frame(9'h03C, 8, 2) ^ flip, len, 32);
    rdat = 32'h0;
    for (k = 0; k < 200 && rdat[7] !== 1'b1; k++) bus(1'b0, `USC_ADDR_STAT_A, 8'h00);
    chk("rx status", rdat & 32'h1C, {24'h0, err});
    bus(1'b0, `USC_ADDR_DATA, 8'h00);
    chk("rx data", rdat, 32'h3C);
    repeat (64) @(posedge clk_i);
  endtask
  task automatic t_rx();
    int k;
    rx_one(8'h26, 12'h000, 11, 8'h00);
    rx_one(8'h26, 12'h200, 11, 8'h04);
    rx_one(8'h26, 12'h400, 11, 8'h10);
    rx_one(8'h2E, 12'h000, 12, 8'h00);
    // Three unread characters: two are kept, the third is lost.
    for (k = 0; k < 3; k++) u_peer.send(frame(9'(17 * (k + 1)), 8, 2), 11, 32);
    bus(1'b0, `USC_ADDR_STAT_A, 8'h00);
    chk("head status", rdat & 32'h1C, 32'h0);
    bus(1'b0, `USC_ADDR_DATA, 8'h00);
    chk("head data", rdat, 32'h11);
    bus(1'b0, `USC_ADDR_STAT_A, 8'h00);
    chk("tail overrun", rdat & 32'h1C, 32'h08);
    bus(1'b0, `USC_ADDR_DATA, 8'h00);
    chk("tail data", rdat, 32'h22);
  endtask
  task automatic t_sync();
    realtime t0;
    bus(1'b1, `USC_ADDR_STAT_C, 8'hC6);
    @(negedge clk_i);
    chk("xck drive", {31'h0, xck_oe}, 32'h1);
    fork
      bus(1'b1, `USC_ADDR_DATA, 8'h55);
      u_peer.recv(10, 4, got);
      begin
        @(posedge xck_out);
        t0 = $realtime;
        @(posedge xck_out);
        chk("xck period", 32'(int'($realtime - t0)), 32'h190);
      end
    join
    chk("sync frame", {20'h0, got}, {20'h0, frame(9'h055, 8, 0)});
    repeat (100) @(posedge clk_i);
    bus(1'b1, `USC_ADDR_STAT_C, 8'h06);
    @(negedge clk_i);
    chk("xck release", {31'h0, xck_oe}, 32'h0);
  endtask
  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = {4'h8, 5'h00, 4'h0, 32'h0};
    error_cnt = 0;
    checked = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_tx();
    t_back();
    t_rx();
    t_sync();
    end_sim();
  end
endmodule
bind usc_core usc_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .serial_out_o(serial_out_o), .xck_oe_o(xck_oe_o));
`default_nettype wire
